/* verif/pss_alu_asserts.sv */
// Checker of the write-back port of the datapath
`timescale 1ns/1ps
module pss_alu_asserts import pss_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Issue
  input wire logic op_valid,
  input wire pss_op_e op_code,
  input wire logic guard_predicate,
  input wire logic [PSS_DATA_W-1:0] src1_data,
  input wire logic src1_nat,
  input wire logic [PSS_DATA_W-1:0] src2_data,
  input wire logic src2_nat,
  input wire pss_size_e lane_size,
  input wire pss_sat_e sat_form,
  input wire logic shl_use_imm,
  input wire logic [PSS_SHL_CNT_W-1:0] shl_imm,
  // Write-back
  input wire logic result_write,
  input wire logic [PSS_DATA_W-1:0] result_data,
  input wire logic result_nat
);
  // ****************************************************
  // Properties
  // ****************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic go;
  logic sub;
  // Guarded operation and guarded subtract
  assign go = op_valid && guard_predicate;
  assign sub = go && op_code == PSS_OP_SUB;
  property p_nat;
    sub && lane_size != PSS_SIZE_BAD |=> result_nat == ($past(src1_nat) | $past(src2_nat));
  endproperty
  a_nat: assert property (p_nat) else $error("token is not the OR of sources");
  property p_guard;
    op_valid && !guard_predicate |=> !result_write && $stable(result_data) && $stable(result_nat);
  endproperty
  a_guard: assert property (p_guard) else $error("false guard changed result");
  property p_shl_big;
    go && op_code == PSS_OP_SHL && !shl_use_imm && src2_data > 63 |=> result_data == '0;
  endproperty
  a_shl_big: assert property (p_shl_big) else $error("large shift not zero");
  property p_shl_imm;
    go && op_code == PSS_OP_SHL && shl_use_imm |=> result_data == $past(src1_data) << $past(shl_imm);
  endproperty
  a_shl_imm: assert property (p_shl_imm) else $error("immediate shift wrong");
  property p_word;
    sub && lane_size == PSS_SIZE_WORDS ##1 1 |-> result_data[63:32] ==
      $past(src1_data[63:32], 1) - $past(src2_data[63:32], 1);
  endproperty
  a_word: assert property (p_word) else $error("word lane does not wrap");
  property p_byte;
    sub && lane_size == PSS_SIZE_BYTES && sat_form == PSS_SAT_MODULO |=>
      result_data[15:8] == $past(src1_data[15:8]) - $past(src2_data[15:8]);
  endproperty
  a_byte: assert property (p_byte) else $error("byte lane one misplaced");
  property p_sss;
    sub && lane_size == PSS_SIZE_BYTES && sat_form == PSS_SAT_SSS && src1_data[7:0] == 8'h7F
      && src2_data[7] |=> result_data[7:0] == 8'h7F;
  endproperty
  a_sss: assert property (p_sss) else $error("signed byte not clamped high");
  property p_uuu;
    sub && lane_size == PSS_SIZE_HALFWORDS && sat_form == PSS_SAT_UUU
      && src1_data[15:0] < src2_data[15:0] |=> result_data[15:0] == 16'h0000;
  endproperty
  a_uuu: assert property (p_uuu) else $error("unsigned half not clamped low");
endmodule

bind pss_alu pss_alu_asserts u_asserts (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .op_valid(op_valid),
  .op_code(op_code),
  .guard_predicate(guard_predicate),
  .src1_data(src1_data),
  .src1_nat(src1_nat),
  .src2_data(src2_data),
  .src2_nat(src2_nat),
  .lane_size(lane_size),
  .sat_form(sat_form),
  .shl_use_imm(shl_use_imm),
  .shl_imm(shl_imm),
  .result_write(result_write),
  .result_data(result_data),
  .result_nat(result_nat)
);

/* verif/pss_alu_test.sv */
// Self-checking bench of the packed subtract and shift datapath
`timescale 1ns/1ps
module pss_alu_test import pss_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic op_valid = 1'b0;
  pss_op_e op_code = PSS_OP_NONE;
  pss_size_e lane_size = PSS_SIZE_BYTES;
  pss_sat_e sat_form = PSS_SAT_MODULO;
  logic guard_predicate = 1'b0;
  logic src1_nat = 1'b0;
  logic src2_nat = 1'b0;
  logic shl_use_imm = 1'b0;
  logic [1:0] add_shift = 2'h1;
  logic [5:0] shl_imm = 6'h00;
  logic [6:0] dest_index = 7'h00;
  logic [63:0] src1_data = 64'h0;
  logic [63:0] src2_data = 64'h0;
  logic result_valid, result_write, result_nat, exp_w;
  logic exp_v = 1'b0;
  logic [6:0] result_index, exp_i;
  logic [63:0] result_data;
  logic [64:0] exp_r = '0;
  logic [64:0] shadow [128] = '{default: '0};
  logic [31:0] r;
  int seed = 65;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  // Design and register file
  pss_alu dut (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .op_valid(op_valid),
    .op_code(op_code),
    .guard_predicate(guard_predicate),
    .dest_index(dest_index),
    .src1_data(src1_data),
    .src1_nat(src1_nat),
    .src2_data(src2_data),
    .src2_nat(src2_nat),
    .lane_size(lane_size),
    .sat_form(sat_form),
    .add_shift(add_shift),
    .shl_use_imm(shl_use_imm),
    .shl_imm(shl_imm),
    .result_valid(result_valid),
    .result_write(result_write),
    .result_index(result_index),
    .result_data(result_data),
    .result_nat(result_nat)
  );
  pss_regfile_model u_model (
    .sys_clk(sys_clk),
    .result_write(result_write),
    .result_index(result_index),
    .result_data(result_data),
    .result_nat(result_nat)
  );
  // Clock and hang limit
  always #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      end_of_test();
    end
  end
  // ****************************************************
  // Tasks and models
  // ****************************************************
  task automatic check(string name, logic [64:0] seen, logic [64:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] sub_lane(longint x, longint y, int w, pss_sat_e s);
    longint h;
    longint d;
    h = longint'(1) << (w - 1);
    if (s == PSS_SAT_SSS) x = (x ^ h) - h;
    if (s != PSS_SAT_UUU) y = (y ^ h) - h;
    d = x - y;
    if (w == 32 || s == PSS_SAT_MODULO) return 32'(d);
    if (s == PSS_SAT_SSS) return 32'(d > h - 1 ? h - 1 : d < -h ? -h : d);
    return 32'(d > 2 * h - 1 ? 2 * h - 1 : d < 0 ? 0 : d);
  endfunction
  function automatic logic [63:0] expect_data(pss_op_e op, pss_size_e sz, pss_sat_e s,
      logic [63:0] a, logic [63:0] b, logic [1:0] sh, logic ui, logic [5:0] im);
    logic [63:0] res;
    longint t;
    longint m;
    int w;
    res = '0;
    if (op == PSS_OP_SHL) return ui ? a << im : b > 63 ? '0 : a << b;
    w = op == PSS_OP_SUB ? 8 << sz : 16;
    m = (longint'(1) << w) - 1;
    for (int i = 0; i < 64 / w; i++) begin
      if (op == PSS_OP_SUB) t = sub_lane((a >> i * w) & m, (b >> i * w) & m, w, s);
      else t = ($signed(a[i * 16 +: 16]) >>> sh) + $signed(b[i * 16 +: 16]);
      if (op != PSS_OP_SUB) t = t > 32767 ? 32767 : t < -32768 ? -32768 : t;
      res = res | 64'((t & m) << i * w);
    end
    return res;
  endfunction
  // Check the op issued one cycle ago, then track the register file
  task automatic retire();
    @(posedge sys_clk);
    #1;
    check("result_valid", result_valid, exp_v);
    if (exp_v) check("result_write", result_write, exp_w);
    if (exp_v) check("result_index", result_index, exp_i);
    check("result", {result_nat, result_data}, exp_r);
    if (exp_v && exp_w) shadow[exp_i] = exp_r;
    exp_v = 1'b0;
  endtask
  task automatic issue(pss_op_e op, pss_size_e sz, pss_sat_e s, logic [63:0] a,
      logic [63:0] b, logic [1:0] sh, logic ui, logic [5:0] im, logic g);
    retire();
    op_valid = 1'b1;
    op_code = op;
    lane_size = sz;
    sat_form = s;
    {add_shift, shl_use_imm, shl_imm, guard_predicate} = {sh, ui, im, g};
    {src1_data, src2_data, src1_nat, src2_nat} = {a, b, 2'($random(seed))};
    dest_index = 7'($random(seed));
    {exp_v, exp_i} = {1'b1, dest_index};
    exp_w = g && op != PSS_OP_NONE && !(op == PSS_OP_SUB && sz == PSS_SIZE_BAD);
    if (exp_w) exp_r = {src1_nat | src2_nat, expect_data(op, sz, s, a, b, sh, ui, im)};
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    issue(PSS_OP_SUB, PSS_SIZE_BYTES, PSS_SAT_SSS, 64'h807F, 64'h0180, 2'h1, 1'b0, 6'h00, 1'b1);
    issue(PSS_OP_SUB, PSS_SIZE_BYTES, PSS_SAT_UUS, 64'h00FF, 64'h01FF, 2'h1, 1'b0, 6'h00, 1'b1);
    issue(PSS_OP_SUB, PSS_SIZE_HALFWORDS, PSS_SAT_UUU, 64'h0001_FFFF_0001, 64'h0002_0001_FFFF,
      2'h1, 1'b0, 6'h00, 1'b1);
    issue(PSS_OP_SUB, PSS_SIZE_HALFWORDS, PSS_SAT_SSS, 64'h80007FFF, 64'h1FFFF, 2'h1, 1'b0, 6'h00, 1'b1);
    issue(PSS_OP_SHR_ADD, PSS_SIZE_BAD, PSS_SAT_SSS, 64'h800080007FFF, 64'h80007FFF7FFF, 2'h1,
      1'b0, 6'h00, 1'b1);
    issue(PSS_OP_SHL, PSS_SIZE_BYTES, PSS_SAT_UUU, 64'h3, 64'h40, 2'h1, 1'b0, 6'h00, 1'b1);
    issue(PSS_OP_SHL, PSS_SIZE_BYTES, PSS_SAT_UUU, 64'h3, 64'h3F, 2'h1, 1'b1, 6'h3F, 1'b1);
    issue(PSS_OP_SUB, PSS_SIZE_BAD, PSS_SAT_UUU, 64'h5, 64'h1, 2'h1, 1'b0, 6'h00, 1'b1);
    $display("Corner test done");
    for (int k = 0; k < 400; k++) begin
      r = $random(seed);
      issue(pss_op_e'(r[1:0]), pss_size_e'(r[3:2]), pss_sat_e'(r[5:4]),
        {$random(seed), $random(seed)}, {$random(seed), $random(seed)} >> r[20:15],
        2'h1 + 2'(r[7:6] % 3), r[8], r[14:9], r[23:21] != 3'h0);
    end
    $display("Random test done");
    retire();
    op_valid = 1'b0;
    retire();
    for (int k = 0; k < 128; k++) begin
      check("register", u_model.regs[k], shadow[k]);
    end
    $display("Register file test done");
    end_of_test();
  end
endmodule

/* verif/pss_regfile_model.sv */
// Model of the general register file behind the write-back port
`timescale 1ns/1ps
module pss_regfile_model import pss_pkg::*; (
  // Clock
  input wire logic sys_clk,
  // Write-back
  input wire logic result_write,
  input wire logic [PSS_IDX_W-1:0] result_index,
  input wire logic [PSS_DATA_W-1:0] result_data,
  input wire logic result_nat
);
  logic [PSS_DATA_W:0] regs [128] = '{default: '0};
  // Store each write with its token; no write leaves the entry alone
  always @(posedge sys_clk) begin
    if (result_write === 1'b1) begin
      regs[result_index] <= {result_nat, result_data};
    end
  end
endmodule

/* verilog/pss_alu.sv */
// Packed shift-right-add, packed subtract and 64-bit shift left datapath
`timescale 1ns/1ps
module pss_alu import pss_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Issue
  input wire logic op_valid,
  input wire pss_op_e op_code,
  input wire logic guard_predicate,
  input wire logic [PSS_IDX_W-1:0] dest_index,
  // Source operands from the general registers
  input wire logic [PSS_DATA_W-1:0] src1_data,
  input wire logic src1_nat,
  input wire logic [PSS_DATA_W-1:0] src2_data,
  input wire logic src2_nat,
  // Operation options
  input wire pss_size_e lane_size,
  input wire pss_sat_e sat_form,
  input wire logic [PSS_ADD_SHIFT_W-1:0] add_shift,
  input wire logic shl_use_imm,
  input wire logic [PSS_SHL_CNT_W-1:0] shl_imm,
  // Write-back to the general registers
  output logic result_valid,
  output logic result_write,
  output logic [PSS_IDX_W-1:0] result_index,
  output logic [PSS_DATA_W-1:0] result_data,
  output logic result_nat
);

  // ****************************************************
  // Declarations
  // ****************************************************
  // Output registers and their next values
  logic result_valid_r;
  logic result_write_r;
  logic result_write_nxt;
  logic [PSS_IDX_W-1:0] result_index_r;
  logic [PSS_DATA_W-1:0] result_data_r;
  logic [PSS_DATA_W-1:0] result_data_nxt;
  logic result_nat_r;
  logic result_nat_nxt;
  // Result of each operation, all computed every cycle
  logic [PSS_DATA_W-1:0] shr_add_res;
  logic [PSS_DATA_W-1:0] sub_byte_res;
  logic [PSS_DATA_W-1:0] sub_half_res;
  logic [PSS_DATA_W-1:0] sub_word_res;
  logic [PSS_DATA_W-1:0] sub_res;
  logic [PSS_DATA_W-1:0] shl_res;
  // Shift-left count and its range check
  logic [PSS_DATA_W-1:0] shl_count;
  logic shl_too_far;
  // Low while the subtract names the unused lane size
  logic sub_size_ok;

  // ****************************************************
  // Packed shift right and add
  // ****************************************************
  // Every lane is computed in parallel whatever the operation; the result
  // select below decides which one reaches the register. One extra bit
  // of headroom per lane is enough, so no wider adder is spent here.
  genvar gi;
  generate
    for (gi = 0; gi < PSS_HALF_LANES; gi++) begin : g_shr_add
      logic signed [PSS_HALF_W:0] lane_x;
      logic signed [PSS_HALF_W:0] lane_y;
      logic signed [PSS_HALF_W:0] lane_shifted;
      logic signed [PSS_HALF_W:0] lane_sum;
      logic [PSS_HALF_W-1:0] lane_res;

      // Sign-extend both lanes, shift arithmetically, add, clamp
      always_comb begin
        lane_x = {src1_data[gi*PSS_HALF_W+PSS_HALF_W-1],
                  src1_data[gi*PSS_HALF_W +: PSS_HALF_W]};
        lane_y = {src2_data[gi*PSS_HALF_W+PSS_HALF_W-1],
                  src2_data[gi*PSS_HALF_W +: PSS_HALF_W]};
        // Count of zero passes the lane through unshifted
        lane_shifted = lane_x >>> add_shift;
        lane_sum = lane_shifted + lane_y;
        lane_res = lane_sum[PSS_HALF_W-1:0];
        // Seventeen bits always hold the sum, so the compares against both limits are exact
        if (lane_sum > $signed({1'b0, PSS_HALF_SMAX})) begin
          lane_res = PSS_HALF_SMAX;
        end else if (lane_sum < $signed({1'b1, PSS_HALF_SMIN})) begin
          lane_res = PSS_HALF_SMIN;
        end
      end

      // Lane zero lands in the low bits
      assign shr_add_res[gi*PSS_HALF_W +: PSS_HALF_W] = lane_res;
    end
  endgenerate

  // ****************************************************
  // Packed subtract, byte lanes
  // ****************************************************
  generate
    for (gi = 0; gi < PSS_BYTE_LANES; gi++) begin : g_sub_byte
      // Each lane carries two guard bits, enough for the widest saturating
      // difference, so the clamp compares exact values and never wraps first
      // Byte lane i occupies bits 8i+7 down to 8i
      pss_lane_sub #(
        .W(PSS_BYTE_W)
      ) u_lane (
        .minuend(src1_data[gi*PSS_BYTE_W +: PSS_BYTE_W]),
        .subtrahend(src2_data[gi*PSS_BYTE_W +: PSS_BYTE_W]),
        .sat_form(sat_form),
        .sat_allowed(1'b1),
        .diff(sub_byte_res[gi*PSS_BYTE_W +: PSS_BYTE_W])
      );
    end
  endgenerate

  // ****************************************************
  // Packed subtract, halfword lanes
  // ****************************************************
  generate
    for (gi = 0; gi < PSS_HALF_LANES; gi++) begin : g_sub_half
      // Halfword lanes reuse the byte lane logic at width sixteen
      pss_lane_sub #(
        .W(PSS_HALF_W)
      ) u_lane (
        .minuend(src1_data[gi*PSS_HALF_W +: PSS_HALF_W]),
        .subtrahend(src2_data[gi*PSS_HALF_W +: PSS_HALF_W]),
        .sat_form(sat_form),
        .sat_allowed(1'b1),
        .diff(sub_half_res[gi*PSS_HALF_W +: PSS_HALF_W])
      );
    end
  endgenerate

  // ****************************************************
  // Packed subtract, word lanes
  // ****************************************************
  generate
    for (gi = 0; gi < PSS_WORD_LANES; gi++) begin : g_sub_word
      // Word lanes ignore the saturation select and always wrap
      // The select still reaches them, so sat_allowed masks it off
      pss_lane_sub #(
        .W(PSS_WORD_W)
      ) u_lane (
        .minuend(src1_data[gi*PSS_WORD_W +: PSS_WORD_W]),
        .subtrahend(src2_data[gi*PSS_WORD_W +: PSS_WORD_W]),
        .sat_form(sat_form),
        .sat_allowed(1'b0),
        .diff(sub_word_res[gi*PSS_WORD_W +: PSS_WORD_W])
      );
    end
  endgenerate

  // The unused size code is not a legal subtract; it completes with no
  // write rather than corrupting the destination
  // Lane size picks one of the three packed results
  always_comb begin
    sub_res = PSS_DATA_RST;
    sub_size_ok = 1'b1;
    unique case (lane_size)
      PSS_SIZE_BYTES: begin
        sub_res = sub_byte_res;
      end
      PSS_SIZE_HALFWORDS: begin
        sub_res = sub_half_res;
      end
      PSS_SIZE_WORDS: begin
        sub_res = sub_word_res;
      end
      PSS_SIZE_BAD: begin
        sub_size_ok = 1'b0;
      end
    endcase
  end

  // ****************************************************
  // 64-bit shift left
  // ****************************************************
  // Immediate count is zero-extended; register count uses all 64 bits
  always_comb begin
    if (shl_use_imm) begin
      shl_count = {{(PSS_DATA_W-PSS_SHL_CNT_W){1'b0}}, shl_imm};
    end else begin
      shl_count = src2_data;
    end
  end

  // A six-bit shifter alone would wrap counts of 64 and more, so the
  // whole register count is range-checked before the shifter sees it
  assign shl_too_far = shl_count > PSS_SHL_MAX_CNT;

  // Out-of-range counts clear the word; otherwise low count bits shift
  always_comb begin
    if (shl_too_far) begin
      shl_res = PSS_DATA_RST;
    end else begin
      shl_res = src1_data << shl_count[PSS_SHL_CNT_W-1:0];
    end
  end

  // ****************************************************
  // Result select
  // ****************************************************
  // Token of the result: OR of both sources, for every operation
  assign result_nat_nxt = src1_nat | src2_nat;

  // Picks the result and decides whether it is written back; a false
  // guard or an illegal code still completes, only without a write
  always_comb begin
    result_data_nxt = PSS_DATA_RST;
    result_write_nxt = op_valid && guard_predicate;
    unique case (op_code)
      PSS_OP_SHR_ADD: begin
        result_data_nxt = shr_add_res;
      end
      PSS_OP_SUB: begin
        result_data_nxt = sub_res;
        if (!sub_size_ok) begin
          result_write_nxt = 1'b0;
        end
      end
      PSS_OP_SHL: begin
        result_data_nxt = shl_res;
      end
      PSS_OP_NONE: begin
        result_write_nxt = 1'b0;
      end
    endcase
  end

  // ****************************************************
  // Output registers
  // ****************************************************
  // Completion marker, one cycle after every issued op, written or not
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_valid_r <= 1'b0;
    end else begin
      result_valid_r <= op_valid;
    end
  end

  // Write strobe, a single-cycle pulse per writing op
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_write_r <= 1'b0;
    end else begin
      result_write_r <= result_write_nxt;
    end
  end

  // Destination number travels with the completion marker
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_index_r <= PSS_IDX_RST;
    end else begin
      result_index_r <= dest_index;
    end
  end

  // Data held when nothing is written, so a refused op leaves it alone
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_data_r <= PSS_DATA_RST;
    end else if (result_write_nxt) begin
      result_data_r <= result_data_nxt;
    end
  end

  // Token follows the same write enable as the data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_nat_r <= 1'b0;
    end else if (result_write_nxt) begin
      result_nat_r <= result_nat_nxt;
    end
  end

  // Write-back ports
  assign result_valid = result_valid_r;
  assign result_write = result_write_r;
  assign result_index = result_index_r;
  assign result_data = result_data_r;
  assign result_nat = result_nat_r;

endmodule

/* verilog/pss_lane_sub.sv */
// One lane of the packed subtract with its saturation forms
`timescale 1ns/1ps
module pss_lane_sub import pss_pkg::*; #(
  parameter int unsigned W = 8
) (
  // Lane operands
  input wire logic [W-1:0] minuend,
  input wire logic [W-1:0] subtrahend,
  // Form select
  input wire pss_sat_e sat_form,
  input wire logic sat_allowed,
  // Lane result
  output logic [W-1:0] diff
);

  // ****************************************************
  // Extended difference and clamp
  // ****************************************************
  logic signed [W+1:0] ext_a;
  logic signed [W+1:0] ext_b;
  logic signed [W+1:0] wide;
  logic signed [W+1:0] hi_lim;
  logic signed [W+1:0] lo_lim;

  // Extend operands per form, subtract, clamp
  always_comb begin
    ext_a = {2'b00, minuend};
    ext_b = {2'b00, subtrahend};
    hi_lim = {2'b00, {W{1'b1}}};
    lo_lim = '0;
    if (sat_form == PSS_SAT_SSS) begin
      ext_a = {{2{minuend[W-1]}}, minuend};
      ext_b = {{2{subtrahend[W-1]}}, subtrahend};
      hi_lim = {3'b000, {(W-1){1'b1}}};
      lo_lim = {3'b111, {(W-1){1'b0}}};
    end else if (sat_form == PSS_SAT_UUS) begin
      ext_b = {{2{subtrahend[W-1]}}, subtrahend};
    end
    wide = ext_a - ext_b;
    diff = wide[W-1:0];
    if (sat_allowed && sat_form != PSS_SAT_MODULO) begin
      if (wide > hi_lim) begin
        diff = hi_lim[W-1:0];
      end else if (wide < lo_lim) begin
        diff = lo_lim[W-1:0];
      end
    end
  end

endmodule

/* verilog/pss_pkg.sv */
// Package of constants and types for the packed subtract and shift datapath
package pss_pkg;

  // ****************************************************
  // Widths
  // ****************************************************
  localparam int unsigned PSS_DATA_W = 64;
  localparam int unsigned PSS_IDX_W = 7;
  localparam int unsigned PSS_HALF_W = 16;
  localparam int unsigned PSS_HALF_LANES = 4;
  localparam int unsigned PSS_BYTE_W = 8;
  localparam int unsigned PSS_BYTE_LANES = 8;
  localparam int unsigned PSS_WORD_W = 32;
  localparam int unsigned PSS_WORD_LANES = 2;
  localparam int unsigned PSS_ADD_SHIFT_W = 2;
  localparam int unsigned PSS_SHL_CNT_W = 6;

  // ****************************************************
  // Limits and reset values
  // ****************************************************
  localparam logic [15:0] PSS_HALF_SMAX = 16'h7FFF;
  localparam logic [15:0] PSS_HALF_SMIN = 16'h8000;
  localparam logic [63:0] PSS_SHL_MAX_CNT = 64'h0000_0000_0000_003F;
  localparam logic [63:0] PSS_DATA_RST = 64'h0000_0000_0000_0000;
  localparam logic [6:0] PSS_IDX_RST = 7'h00;

  // ****************************************************
  // Operation selects
  // ****************************************************
  typedef enum logic [1:0] {
    PSS_OP_SHR_ADD = 2'b00,
    PSS_OP_SUB = 2'b01,
    PSS_OP_SHL = 2'b10,
    PSS_OP_NONE = 2'b11
  } pss_op_e;

  // Lane sizes of the packed subtract
  typedef enum logic [1:0] {
    PSS_SIZE_BYTES = 2'b00,
    PSS_SIZE_HALFWORDS = 2'b01,
    PSS_SIZE_WORDS = 2'b10,
    PSS_SIZE_BAD = 2'b11
  } pss_size_e;

  // Saturation forms of the packed subtract
  typedef enum logic [1:0] {
    PSS_SAT_MODULO = 2'b00,
    PSS_SAT_SSS = 2'b01,
    PSS_SAT_UUS = 2'b10,
    PSS_SAT_UUU = 2'b11
  } pss_sat_e;

endpackage
